// File: common/axil_reg_if.sv
// AXI4-Lite link between the user request machine and the register slave
interface axil_reg_if;
    import axil_reg_pkg::*;
    addr_t awaddr;
    logic  awvalid;
    logic  awready;
    data_t wdata;
    strb_t wstrb;
    logic  wvalid;
    logic  wready;
    resp_t bresp;
    logic  bvalid;
    logic  bready;
    addr_t araddr;
    logic  arvalid;
    logic  arready;
    data_t rdata;
    resp_t rresp;
    logic  rvalid;
    logic  rready;

    modport master (
        output awaddr, awvalid, wdata, wstrb, wvalid, bready,
        output araddr, arvalid, rready,
        input  awready, wready, bresp, bvalid, arready, rdata, rresp, rvalid
    );
    modport slave (
        input  awaddr, awvalid, wdata, wstrb, wvalid, bready,
        input  araddr, arvalid, rready,
        output awready, wready, bresp, bvalid, arready, rdata, rresp, rvalid
    );
endinterface

// File: common/axil_reg_pkg.sv
// shared constants and types for the user-side register access bridge
package axil_reg_pkg;
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    localparam int STRB_W = 4;
    localparam int RESP_W = 2;
    localparam logic [RESP_W-1:0] RESP_OKAY   = 2'h0;
    localparam logic [RESP_W-1:0] RESP_EXOKAY = 2'h1;
    localparam logic [RESP_W-1:0] RESP_SLVERR = 2'h2;
    localparam logic [RESP_W-1:0] RESP_DECERR = 2'h3;
    // register file depth in words and its word-index bit range
    localparam int REG_WORDS = 16;
    localparam int IDX_W     = 4;
    localparam int IDX_LSB   = 2;
    // width of one byte lane of the data word
    localparam int BYTE_W    = 8;
    localparam logic [ADDR_W-1:0] MAP_LIMIT  = 32'h0000_0040;
    localparam logic [DATA_W-1:0] REG_RESET  = 32'h0000_0000;
    localparam logic [STRB_W-1:0] STRB_NONE  = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_ZERO  = 32'h0000_0000;
    localparam logic [DATA_W-1:0] DATA_ZERO  = 32'h0000_0000;

    // request machine states
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_WRITE = 2'b01,
        ST_READ  = 2'b10,
        ST_ACK   = 2'b11
    } req_state_e;

    typedef logic [ADDR_W-1:0] addr_t;
    typedef logic [DATA_W-1:0] data_t;
    typedef logic [STRB_W-1:0] strb_t;
    typedef logic [RESP_W-1:0] resp_t;

    // address lies outside the implemented map, or is not word aligned
    function automatic logic addr_illegal(input addr_t a);
        return (a >= MAP_LIMIT) || (a[IDX_LSB-1:0] != 2'b00);
    endfunction
endpackage

// File: logic/axil_reg_slave.sv
// AXI4-Lite register slave holding the core's control and status words
module axil_reg_slave
    import axil_reg_pkg::*;
(
    // clock and reset
    input  wire logic  i_mclk,
    input  wire logic  i_rst_n,
    // core side
    input  wire logic  i_stats_snapshot_pulse,
    input  wire axil_reg_pkg::data_t i_status [REG_WORDS],
    output axil_reg_pkg::data_t o_ctrl   [REG_WORDS],
    output logic       o_snapshot,
    // register bus
    axil_reg_if.slave  bus
);
    import axil_reg_pkg::*;

    typedef struct packed {
        logic  aw_held;
        addr_t aw;
        logic  w_held;
        data_t wd;
        strb_t ws;
        logic  bvalid;
        resp_t bresp;
        logic  rvalid;
        resp_t rresp;
        data_t rdata;
        logic  snap;
    } slv_s;

    slv_s  s_q;
    slv_s  s_d;
    logic  wr_fire;
    logic  wr_ok;
    logic  [IDX_W-1:0] rd_idx;
    data_t ctrl_q [REG_WORDS];
    data_t stat_q [REG_WORDS];

    // a write commits once address and data are both held and no
    // response is still waiting, so responses never overlap
    assign wr_fire = s_q.aw_held && s_q.w_held && !s_q.bvalid;
    assign wr_ok   = wr_fire && !addr_illegal(s_q.aw);
    assign rd_idx  = bus.araddr[IDX_LSB +: IDX_W];

    // control words written through the bus
    for (genvar g = 0; g < REG_WORDS; g++)
    begin : g_ctrl
        axil_reg_word u_word (
            .i_mclk (i_mclk),
            .i_rst_n(i_rst_n),
            .i_we   (wr_ok && s_q.aw[IDX_LSB +: IDX_W] == IDX_W'(g)),
            .i_strb (s_q.ws),
            .i_data (s_q.wd),
            .o_q    (ctrl_q[g])
        );
    end

    // status words are frozen on the snapshot pulse for coherent reads
    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n)
        begin
            for (int k = 0; k < REG_WORDS; k++)
                stat_q[k] <= REG_RESET;
        end
        else if (i_stats_snapshot_pulse)
            stat_q <= i_status;
    end

    // handshakes and responses
    always_comb
    begin
        s_d      = s_q;
        s_d.snap = i_stats_snapshot_pulse;
        if (bus.awvalid && !s_q.aw_held)
        begin
            s_d.aw_held = 1'b1;
            s_d.aw      = bus.awaddr;
        end
        if (bus.wvalid && !s_q.w_held)
        begin
            s_d.w_held = 1'b1;
            s_d.wd     = bus.wdata;
            s_d.ws     = bus.wstrb;
        end
        if (wr_fire)
        begin
            s_d.aw_held = 1'b0;
            s_d.w_held  = 1'b0;
            s_d.bvalid  = 1'b1;
            s_d.bresp   = addr_illegal(s_q.aw) ? RESP_SLVERR : RESP_OKAY;
        end
        else if (s_q.bvalid && bus.bready)
            s_d.bvalid = 1'b0;
        if (bus.arvalid && !s_q.rvalid)
        begin
            s_d.rvalid = 1'b1;
            s_d.rresp  = addr_illegal(bus.araddr) ? RESP_SLVERR : RESP_OKAY;
            s_d.rdata  = addr_illegal(bus.araddr) ? DATA_ZERO
                                                  : stat_q[rd_idx];
        end
        else if (s_q.rvalid && bus.rready)
            s_d.rvalid = 1'b0;
    end

    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    // ready only while the holding slot is free; read ready is held
    // high as a level whenever no read data is pending
    assign bus.awready = !s_q.aw_held;
    assign bus.wready  = !s_q.w_held;
    assign bus.arready = !s_q.rvalid;
    assign bus.bvalid  = s_q.bvalid;
    assign bus.bresp   = s_q.bresp;
    assign bus.rvalid  = s_q.rvalid;
    assign bus.rresp   = s_q.rresp;
    assign bus.rdata   = s_q.rdata;
    assign o_ctrl      = ctrl_q;
    assign o_snapshot  = s_q.snap;
endmodule

// File: logic/axil_reg_word.sv
// one register word with byte-lane write strobes
module axil_reg_word
    import axil_reg_pkg::*;
(
    // clock and reset
    input  wire logic                i_mclk,
    input  wire logic                i_rst_n,
    // write port
    input  wire logic                i_we,
    input  wire axil_reg_pkg::strb_t i_strb,
    input  wire axil_reg_pkg::data_t i_data,
    // stored value
    output axil_reg_pkg::data_t      o_q
);
    import axil_reg_pkg::*;

    // synchronous active-low reset; only strobed lanes change
    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n)
            o_q <= REG_RESET;
        else if (i_we)
        begin
            for (int b = 0; b < STRB_W; b++)
                if (i_strb[b])
                    o_q[BYTE_W*b +: BYTE_W] <= i_data[BYTE_W*b +: BYTE_W];
        end
    end
endmodule

// File: logic/axil_user_master.sv
// user-side request machine driving AXI4-Lite register accesses
module axil_user_master
    import axil_reg_pkg::*;
(
    // clock and reset
    input  wire logic   i_mclk,
    input  wire logic   i_rst_n,
    // user requests
    input  wire logic   i_read_req,
    input  wire logic   i_write_req,
    input  wire axil_reg_pkg::addr_t i_addr,
    input  wire axil_reg_pkg::data_t i_wdata,
    input  wire axil_reg_pkg::strb_t i_wstrb,
    // user answers
    output axil_reg_pkg::data_t o_rdata,
    output logic        o_done,
    output logic        o_write_err,
    output logic        o_read_err,
    output logic        o_busy,
    // register bus
    axil_reg_if.master  bus
);
    import axil_reg_pkg::*;

    // only the slave-error code counts as an error; the other codes are
    // taken as success, since this slave sends no code but okay and slave-error
    function automatic logic resp_is_err(input resp_t r);
        return (r == RESP_SLVERR);
    endfunction

    // whole machine state: request fields, bus drives and user answers
    typedef struct packed {
        req_state_e st;
        // write channel drives
        addr_t      awaddr;
        logic       awvalid;
        data_t      wdata;
        strb_t      wstrb;
        logic       wvalid;
        logic       bready;
        // read channel drives
        addr_t      araddr;
        logic       arvalid;
        logic       rready;
        // user answers
        data_t      rdata;
        logic       done;
        logic       werr;
        logic       rerr;
        logic       busy;
    } mst_s;

    mst_s s_q;
    mst_s s_d;

    // next-state logic; address and data valids drop once each handshake
    // completes so a slave never sees a second copy of the request
    always_comb
    begin
        s_d      = s_q;
        s_d.done = 1'b0;
        case (s_q.st)
            // requests are looked at only here, so a request raised while
            // busy is ignored rather than queued; the user must hold it
            ST_IDLE:
            begin
                // the read is tested first, so it wins a tie with a write
                if (i_read_req)
                begin
                    s_d.st      = ST_READ;
                    s_d.araddr  = i_addr;
                    s_d.arvalid = 1'b1;
                    s_d.rready  = 1'b1;
                end
                else if (i_write_req)
                begin
                    s_d.st      = ST_WRITE;
                    s_d.awaddr  = i_addr;
                    s_d.awvalid = 1'b1;
                    s_d.wdata   = i_wdata;
                    s_d.wstrb   = i_wstrb;
                    s_d.wvalid  = 1'b1;
                    s_d.bready  = 1'b1;
                end
            end

            // address and data may be taken on different edges, so each
            // valid is dropped on its own handshake
            ST_WRITE:
            begin
                if (bus.awready)
                    s_d.awvalid = 1'b0;
                if (bus.wready)
                begin
                    s_d.wvalid = 1'b0;
                    s_d.wstrb  = STRB_NONE;
                end
                // the response ends the write; both error flags are
                // rewritten so they always describe the last transfer
                if (bus.bvalid && s_q.bready)
                begin
                    s_d.st     = ST_ACK;
                    s_d.bready = 1'b0;
                    s_d.werr   = resp_is_err(bus.bresp);
                    s_d.rerr   = 1'b0;
                    s_d.done   = 1'b1;
                end
            end

            // read ready is already up, so data is taken on its first edge
            ST_READ:
            begin
                if (bus.arready)
                    s_d.arvalid = 1'b0;
                if (bus.rvalid && s_q.rready)
                begin
                    s_d.st     = ST_ACK;
                    s_d.rready = 1'b0;
                    s_d.rdata  = bus.rdata;
                    s_d.rerr   = resp_is_err(bus.rresp);
                    s_d.werr   = 1'b0;
                    s_d.done   = 1'b1;
                end
            end

            // one cycle of acknowledge, whatever the inputs do
            ST_ACK:
                s_d.st = ST_IDLE;

            // all four two-bit codes are states, so only an unknown code lands here;
            // it drops every valid and ready and goes idle
            default:
            begin
                s_d.st      = ST_IDLE;
                s_d.awvalid = 1'b0;
                s_d.wvalid  = 1'b0;
                s_d.bready  = 1'b0;
                s_d.arvalid = 1'b0;
                s_d.rready  = 1'b0;
            end
        endcase
        // busy is registered with the state so the user sees a flop
        s_d.busy = (s_d.st != ST_IDLE);
    end

    // single state register, synchronous active-low reset; there is no
    // timeout, so a slave that never answers keeps the machine busy
    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n)
        begin
            s_q.st      <= ST_IDLE;
            s_q.awaddr  <= ADDR_ZERO;
            s_q.awvalid <= 1'b0;
            s_q.wdata   <= DATA_ZERO;
            s_q.wstrb   <= STRB_NONE;
            s_q.wvalid  <= 1'b0;
            s_q.bready  <= 1'b0;
            s_q.araddr  <= ADDR_ZERO;
            s_q.arvalid <= 1'b0;
            s_q.rready  <= 1'b0;
            s_q.rdata   <= DATA_ZERO;
            s_q.done    <= 1'b0;
            s_q.werr    <= 1'b0;
            s_q.rerr    <= 1'b0;
            s_q.busy    <= 1'b0;
        end
        else
            s_q <= s_d;
    end

    // write address and data channels
    assign bus.awaddr  = s_q.awaddr;
    assign bus.awvalid = s_q.awvalid;
    assign bus.wdata   = s_q.wdata;
    assign bus.wstrb   = s_q.wstrb;
    assign bus.wvalid  = s_q.wvalid;

    // write response channel
    assign bus.bready  = s_q.bready;

    // read channels
    assign bus.araddr  = s_q.araddr;
    assign bus.arvalid = s_q.arvalid;
    assign bus.rready  = s_q.rready;

    // user answers, all straight from the state register
    assign o_rdata     = s_q.rdata;
    assign o_done      = s_q.done;
    assign o_write_err = s_q.werr;
    assign o_read_err  = s_q.rerr;
    assign o_busy      = s_q.busy;
endmodule

// File: testbench/axi_lite_user_register_access_fsm_tb.sv
// self-checking bench: request machine and register slave back to back
module axi_lite_user_register_access_fsm_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import axil_reg_pkg::*;
    logic  i_mclk;
    logic  i_rst_n;
    logic  rd_req;
    logic  wr_req;
    addr_t addr;
    data_t wdata;
    strb_t wstrb;
    data_t rdata;
    logic  done;
    logic  werr;
    logic  rerr;
    logic  busy;
    logic  tick;
    logic  snap;
    data_t status [REG_WORDS];
    data_t ctrl   [REG_WORDS];
    int    err_total;
    int    checked;

    axil_reg_if bus_if ();

    axil_user_master u_axil_user_master (
        .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_read_req(rd_req),
        .i_write_req(wr_req), .i_addr(addr), .i_wdata(wdata),
        .i_wstrb(wstrb), .o_rdata(rdata), .o_done(done),
        .o_write_err(werr), .o_read_err(rerr), .o_busy(busy),
        .bus(bus_if.master));

    axil_reg_slave u_axil_reg_slave (
        .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_stats_snapshot_pulse(tick),
        .i_status(status), .o_ctrl(ctrl), .o_snapshot(snap),
        .bus(bus_if.slave));

    axil_reg_asserts u_axil_reg_asserts (
        .i_mclk(i_mclk), .i_rst_n(i_rst_n), .awaddr(bus_if.awaddr),
        .awvalid(bus_if.awvalid), .wvalid(bus_if.wvalid),
        .bvalid(bus_if.bvalid), .bready(bus_if.bready),
        .bresp(bus_if.bresp), .araddr(bus_if.araddr),
        .arvalid(bus_if.arvalid), .arready(bus_if.arready),
        .rvalid(bus_if.rvalid), .rready(bus_if.rready),
        .rresp(bus_if.rresp), .rdata(bus_if.rdata));

    // compare and count; an unknown matches only an unknown in the same bit
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            err_total++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one user request, held over its taking edge, then wait for done
    task automatic xfer(input logic rd, input logic wr, input addr_t a,
                        input data_t d, input strb_t s);
        int n;
        rd_req = rd;
        wr_req = wr;
        addr = a;
        wdata = d;
        wstrb = s;
        @(negedge i_mclk);
        rd_req = 1'b0;
        wr_req = 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 20)
        begin
            @(negedge i_mclk);
            n++;
        end
        check(n < 20, 1'b1);
        @(negedge i_mclk);
        check(done, 1'b0);
        check(busy, 1'b0);
    endtask

    task automatic t_reset();
        check(busy, 1'b0);
        check(done, 1'b0);
        check(ctrl[3], REG_RESET);
        repeat (3) @(negedge i_mclk);
        check(busy, 1'b0);
        $display("test reset finished");
    endtask

    task automatic t_write();
        xfer(1'b0, 1'b1, 32'h0000_000C, 32'h1234_5678, 4'hF);
        check(ctrl[3], 32'h1234_5678);
        check(werr, 1'b0);
        xfer(1'b0, 1'b1, 32'h0000_000C, 32'hFFFF_FFFF, 4'h5);
        check(ctrl[3], 32'h12FF_56FF);
        $display("test write finished");
    endtask

    task automatic t_read();
        tick = 1'b1;
        @(negedge i_mclk);
        tick = 1'b0;
        check(snap, 1'b1);
        xfer(1'b1, 1'b0, 32'h0000_0008, DATA_ZERO, STRB_NONE);
        check(rdata, status[2]);
        check(rerr, 1'b0);
        xfer(1'b1, 1'b0, 32'h0000_003C, DATA_ZERO, STRB_NONE);
        check(rdata, status[15]);
        $display("test read finished");
    endtask

    // illegal places answer with an error and leave the map untouched
    task automatic t_illegal();
        xfer(1'b0, 1'b1, 32'h0000_0040, 32'hAAAA_AAAA, 4'hF);
        check(werr, 1'b1);
        xfer(1'b0, 1'b1, 32'h0000_000E, 32'hAAAA_AAAA, 4'hF);
        check(werr, 1'b1);
        check(ctrl[3], 32'h12FF_56FF);
        xfer(1'b1, 1'b0, 32'h0000_0044, DATA_ZERO, STRB_NONE);
        check(rerr, 1'b1);
        check(rdata, DATA_ZERO);
        xfer(1'b0, 1'b1, 32'h0000_0000, 32'h0000_00A5, 4'hF);
        check(werr, 1'b0);
        xfer(1'b1, 1'b0, 32'h0000_0000, DATA_ZERO, STRB_NONE);
        check(rerr, 1'b0);
        $display("test illegal finished");
    endtask

    // both requests on one edge: the read wins and nothing is written
    task automatic t_priority();
        xfer(1'b1, 1'b1, 32'h0000_0004, 32'hDEAD_BEEF, 4'hF);
        check(rdata, status[1]);
        check(ctrl[1], REG_RESET);
        check(busy, 1'b0);
        $display("test priority finished");
    endtask

    // a read pulse while a write is busy is dropped, not queued
    task automatic t_busy();
        data_t prev;
        prev = rdata;
        wr_req = 1'b1;
        addr = 32'h0000_0014;
        wdata = 32'h0BAD_F00D;
        wstrb = 4'hF;
        @(negedge i_mclk);
        wr_req = 1'b0;
        rd_req = 1'b1;
        @(negedge i_mclk);
        rd_req = 1'b0;
        repeat (4) @(negedge i_mclk);
        check(ctrl[5], 32'h0BAD_F00D);
        check(rdata, prev);
        check(busy, 1'b0);
        check(done, 1'b0);
        $display("test busy finished");
    endtask

    // reset in the middle of a write: back to idle, nothing written
    task automatic t_mid_reset();
        wr_req = 1'b1;
        addr = 32'h0000_0010;
        wdata = 32'h5A5A_5A5A;
        wstrb = 4'hF;
        @(negedge i_mclk);
        wr_req = 1'b0;
        @(negedge i_mclk);
        i_rst_n = 1'b0;
        repeat (2) @(negedge i_mclk);
        i_rst_n = 1'b1;
        check(busy, 1'b0);
        check(done, 1'b0);
        check(ctrl[4], REG_RESET);
        check(ctrl[3], REG_RESET);
        xfer(1'b1, 1'b0, 32'h0000_0010, DATA_ZERO, STRB_NONE);
        check(rdata, REG_RESET);
        check(rerr, 1'b0);
        tick = 1'b1;
        @(negedge i_mclk);
        tick = 1'b0;
        xfer(1'b1, 1'b0, 32'h0000_0014, DATA_ZERO, STRB_NONE);
        check(rdata, status[5]);
        $display("test mid reset finished");
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial
    begin
        i_mclk = 1'b0;
        forever #2 i_mclk = ~i_mclk;
    end

    // the tests need well under 1000 cycles
    initial
    begin
        #20000;
        err_total++;
        stop_test();
    end

    initial
    begin
        err_total = 0;
        checked = 0;
        i_rst_n = 1'b0;
        rd_req = 1'b0;
        wr_req = 1'b0;
        addr = ADDR_ZERO;
        wdata = DATA_ZERO;
        wstrb = STRB_NONE;
        tick = 1'b0;
        for (int i = 0; i < REG_WORDS; i++)
            status[i] = 32'hC0DE_0000 + 32'(i);
        repeat (10) @(negedge i_mclk);
        i_rst_n = 1'b1;
        t_reset();
        t_write();
        t_read();
        t_illegal();
        t_priority();
        t_busy();
        t_mid_reset();
        stop_test();
    end
endmodule

// File: testbench/axil_reg_asserts.sv
// timing checks on the link between request machine and register slave
module axil_reg_asserts
    import axil_reg_pkg::*;
(
    // clock and reset
    input wire logic  i_mclk,
    input wire logic  i_rst_n,
    // write channels
    input wire addr_t awaddr,
    input wire logic  awvalid,
    input wire logic  wvalid,
    input wire logic  bvalid,
    input wire logic  bready,
    input wire resp_t bresp,
    // read channels
    input wire addr_t araddr,
    input wire logic  arvalid,
    input wire logic  arready,
    input wire logic  rvalid,
    input wire logic  rready,
    input wire resp_t rresp,
    input wire data_t rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_rst_n);

    // own decoder, so a slip shared with the slave still shows
    function automatic logic bad(input addr_t a);
        return (a >= 32'h0000_0040) || (a[1:0] != 2'b00);
    endfunction

    a_aw_w_pair: assert property (awvalid |-> wvalid)
        else $error("address valid without data valid");
    a_w_aw_pair: assert property (wvalid |-> awvalid)
        else $error("data valid without address valid");
    a_bready_up: assert property (bvalid |-> bready)
        else $error("write response not taken");
    a_b_one_beat: assert property (bvalid && bready |=> !bvalid)
        else $error("write response held after handshake");
    a_b_after_w: assert property ($rose(bvalid) |-> $past(wvalid, 2))
        else $error("write response without prior write");
    a_bresp_code: assert property ($rose(bvalid) |->
        bresp == (bad($past(awaddr, 2)) ? RESP_SLVERR : RESP_OKAY))
        else $error("write response code wrong");
    a_ar_once: assert property (arvalid && arready |=> !arvalid)
        else $error("read address valid held after accept");
    a_r_after_ar: assert property ($rose(rvalid) |->
        $past(arvalid) && $past(arready))
        else $error("read data without accepted address");
    a_rready_up: assert property (rvalid |-> rready)
        else $error("read data not taken");
    a_rresp_code: assert property ($rose(rvalid) |->
        rresp == (bad($past(araddr)) ? RESP_SLVERR : RESP_OKAY))
        else $error("read response code wrong");
    a_r_err_zero: assert property (rvalid && rresp[1] |-> rdata == 32'h0)
        else $error("error read returned data");
endmodule
